// ---- include/pbu_pkg.sv ----
// Purpose: Shared constants for the four-channel PWM generator with brake
// Assumes: Byte-wide register port, 8-bit register offsets
// Notes:   Offsets of high-bits and brake/interrupt registers are local choices
package pbu_pkg;
  localparam int        NUM_CH       = 4;
  localparam int        CNT_W        = 10;
  localparam int        ADDR_W       = 8;
  localparam int        DATA_W       = 8;
  // Register offsets
  localparam logic [7:0] OFF_PERIOD_LOW  = 8'hD9;
  localparam logic [7:0] OFF_DUTY0_LOW   = 8'hDA;
  localparam logic [7:0] OFF_DUTY1_LOW   = 8'hDB;
  localparam logic [7:0] OFF_CONTROL_ONE = 8'hDC;
  localparam logic [7:0] OFF_DUTY2_LOW   = 8'hD1;
  localparam logic [7:0] OFF_DUTY3_LOW   = 8'hD2;
  localparam logic [7:0] OFF_HIGH_BITS   = 8'hD3;
  localparam logic [7:0] OFF_HIGH_PERIOD = 8'hD4;
  localparam logic [7:0] OFF_BRAKE_CTRL  = 8'hD5;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'hD6;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'hD7;
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'hD8;
  // Control one fields
  localparam int        CTL_RUN_POS   = 7;
  localparam int        CTL_LOAD_POS  = 6;
  localparam int        CTL_CF_POS    = 5;
  localparam int        CTL_CLR_POS   = 4;
  // Brake control fields
  localparam int        BRK_MODE_POS  = 7;
  localparam int        BRK_POL_POS   = 6;
  localparam int        BRK_PEN_POS   = 5;
  localparam int        BRK_EN_POS    = 4;
  // Status bits
  localparam int        IRQ_BRAKE_POS = 0;
  localparam int        IRQ_CF_POS    = 1;
  localparam int        IRQ_W         = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [9:0] RST_PERIOD   = 10'h3FF;
  localparam logic [9:0] RST_COUNT    = 10'h000;
endpackage

// ---- design/pbu_sync.sv ----
// Purpose: Two-stage synchroniser for the brake pin
// Assumes: Input is asynchronous to core_clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
module pbu_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;
  logic next_meta;
  logic next_out;
  always_comb begin
    next_meta = async_in;
    next_out  = meta;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_out;
    end
  end
endmodule

// ---- design/pbu_channel.sv ----
// Purpose: One PWM channel compare, invert and brake override
// Assumes: Counter and duty on the same clock
// Notes:   Output registered so top outputs come from flops
`timescale 1ns/1ns
module pbu_channel (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [pbu_pkg::CNT_W-1:0] count,
  input  wire logic [pbu_pkg::CNT_W-1:0] duty,
  input  wire logic                    running,
  input  wire logic                    invert,
  input  wire logic                    brake,
  input  wire logic                    brake_level,
  output logic                         pwm_out
);
  import pbu_pkg::*;
  logic next_pwm;
  always_comb begin
    if (brake) begin
      next_pwm = brake_level;
    end else if (running) begin
      next_pwm = (count < duty) ^ invert;
    end else begin
      next_pwm = invert;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_pwm;
    end
  end
endmodule

// ---- design/pbu_top.sv ----
// Purpose: Four-channel PWM generator with brake and register port
// Assumes: Byte register port, read data one cycle after read strobe
// Notes:   Brake pin synchronised, so pin brake lands three cycles late
//
// Summary of operation
// - Four channels share one 10-bit period counter.
// - Low eight bits of the period live in a writable register.
// - Each channel has its own low-byte duty register.
// - Brake enable 0 never brakes; 1 follows pin enable and mode.
// - Polarity 0 means pin low requests brake; 1 means high.
// - While braking each output takes its own brake level bit.
// - Pin enable 0, mode 0: brake under software enable bit.
// - Pin enable 0, mode 1: brake while stopped, release while running.
// - Pin enable 1, mode 0: pin brake, run cleared, flag set.
`timescale 1ns/1ns
module pbu_top (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [pbu_pkg::ADDR_W-1:0] addr,
  input  wire logic [pbu_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [pbu_pkg::DATA_W-1:0] rdata,
  input  wire logic                       brake_pin,
  output logic      [pbu_pkg::NUM_CH-1:0] pwm_out,
  output logic                            irq
);
  import pbu_pkg::*;

  logic [7:0]       period_low;
  logic [1:0]       period_high;
  logic [7:0]       duty_low [NUM_CH];
  logic [7:0]       duty_high;
  logic [7:0]       control_one;
  logic [7:0]       brake_ctrl;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] period_act;
  logic [CNT_W-1:0] duty_act [NUM_CH];
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic             brake_pin_s;
  logic             brake_req;
  logic             brake_on;
  logic             pin_brake;
  logic             wrap;

  logic [7:0]       next_period_low;
  logic [1:0]       next_period_high;
  logic [7:0]       next_duty_low [NUM_CH];
  logic [7:0]       next_duty_high;
  logic [7:0]       next_control_one;
  logic [7:0]       next_brake_ctrl;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_period_act;
  logic [CNT_W-1:0] next_duty_act [NUM_CH];
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_enable;
  logic [7:0]       next_rdata;
  logic             next_irq;

  wire logic run     = control_one[CTL_RUN_POS];
  wire logic brk_en  = brake_ctrl[BRK_EN_POS];
  wire logic brk_pen = brake_ctrl[BRK_PEN_POS];
  wire logic brk_md  = brake_ctrl[BRK_MODE_POS];

  pbu_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (brake_pin),
    .sync_out (brake_pin_s)
  );

  // Brake condition decode
  always_comb begin
    brake_req = brake_pin_s ^ ~brake_ctrl[BRK_POL_POS];
    pin_brake = brk_en && brk_pen && !brk_md && brake_req;
    brake_on  = 1'b0;
    if (brk_en) begin
      case ({brk_pen, brk_md})
        2'b00:   brake_on = 1'b1;
        2'b01:   brake_on = !run;
        2'b10:   brake_on = brake_req;
        default: brake_on = 1'b0;
      endcase
    end
  end

  // Counter and double-buffered compare values
  always_comb begin
    wrap            = (count >= period_act);
    next_count      = count;
    next_period_act = period_act;
    for (int i = 0; i < NUM_CH; i++) begin
      next_duty_act[i] = duty_act[i];
    end
    if (!run || control_one[CTL_CLR_POS]) begin
      next_count = RST_COUNT;
    end else if (wrap) begin
      next_count = RST_COUNT;
    end else begin
      next_count = count + 10'h001;
    end
    // Shadow update at wrap with the load bit set, or while stopped, avoids glitched periods
    if (!run || (wrap && control_one[CTL_LOAD_POS])) begin
      next_period_act = {period_high, period_low};
      for (int i = 0; i < NUM_CH; i++) begin
        next_duty_act[i] = {duty_high[2*i +: 2], duty_low[i]};
      end
    end
  end

  // Register writes, hardware clears and sticky flags
  always_comb begin
    next_period_low  = period_low;
    next_period_high = period_high;
    next_duty_high   = duty_high;
    next_control_one = control_one;
    next_brake_ctrl  = brake_ctrl;
    next_irq_enable  = irq_enable;
    next_irq_status  = irq_status;
    for (int i = 0; i < NUM_CH; i++) begin
      next_duty_low[i] = duty_low[i];
    end
    if (wr_stb) begin
      case (addr)
        OFF_PERIOD_LOW:  next_period_low = wdata;
        OFF_DUTY0_LOW:   next_duty_low[0] = wdata;
        OFF_DUTY1_LOW:   next_duty_low[1] = wdata;
        OFF_DUTY2_LOW:   next_duty_low[2] = wdata;
        OFF_DUTY3_LOW:   next_duty_low[3] = wdata;
        OFF_HIGH_BITS:   next_duty_high = wdata;
        OFF_HIGH_PERIOD: next_period_high = wdata[1:0];
        OFF_CONTROL_ONE: next_control_one = {wdata[7:6], control_one[CTL_CF_POS], wdata[4:0]};
        OFF_BRAKE_CTRL:  next_brake_ctrl = wdata;
        OFF_IRQ_ENABLE:  next_irq_enable = wdata[IRQ_W-1:0];
        OFF_IRQ_CLEAR:   next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
        default:         next_irq_enable = irq_enable;
      endcase
    end
    // Counter clear is a one-shot
    if (control_one[CTL_CLR_POS]) begin
      next_control_one[CTL_CLR_POS] = 1'b0;
    end
    // Set beats a same-cycle clear
    if (run && wrap) begin
      next_control_one[CTL_CF_POS] = 1'b1;
      next_irq_status[IRQ_CF_POS]  = 1'b1;
    end
    if (pin_brake) begin
      next_control_one[CTL_RUN_POS]  = 1'b0;
      next_irq_status[IRQ_BRAKE_POS] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  // Read mux, data stand the cycle after the strobe
  always_comb begin
    next_rdata = RST_BYTE;
    if (rd_stb) begin
      case (addr)
        OFF_PERIOD_LOW:  next_rdata = period_low;
        OFF_DUTY0_LOW:   next_rdata = duty_low[0];
        OFF_DUTY1_LOW:   next_rdata = duty_low[1];
        OFF_DUTY2_LOW:   next_rdata = duty_low[2];
        OFF_DUTY3_LOW:   next_rdata = duty_low[3];
        OFF_HIGH_BITS:   next_rdata = duty_high;
        OFF_HIGH_PERIOD: next_rdata = {6'h00, period_high};
        OFF_CONTROL_ONE: next_rdata = control_one;
        OFF_BRAKE_CTRL:  next_rdata = brake_ctrl;
        OFF_IRQ_STATUS:  next_rdata = {6'h00, irq_status};
        OFF_IRQ_ENABLE:  next_rdata = {6'h00, irq_enable};
        default:         next_rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_low  <= RST_PERIOD[7:0];
      period_high <= RST_PERIOD[9:8];
      duty_high   <= RST_BYTE;
      control_one <= RST_BYTE;
      brake_ctrl  <= RST_BYTE;
      irq_status  <= '0;
      irq_enable  <= '0;
      count       <= RST_COUNT;
      period_act  <= RST_PERIOD;
      rdata       <= RST_BYTE;
      irq         <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_low[i] <= RST_BYTE;
        duty_act[i] <= RST_COUNT;
      end
    end else begin
      period_low  <= next_period_low;
      period_high <= next_period_high;
      duty_high   <= next_duty_high;
      control_one <= next_control_one;
      brake_ctrl  <= next_brake_ctrl;
      irq_status  <= next_irq_status;
      irq_enable  <= next_irq_enable;
      count       <= next_count;
      period_act  <= next_period_act;
      rdata       <= next_rdata;
      irq         <= next_irq;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_low[i] <= next_duty_low[i];
        duty_act[i] <= next_duty_act[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      pbu_channel u_ch (
        .core_clk    (core_clk),
        .rst         (rst),
        .count       (count),
        .duty        (duty_act[g]),
        .running     (run),
        .invert      (control_one[g]),
        .brake       (brake_on),
        .brake_level (brake_ctrl[g]),
        .pwm_out     (pwm_out[g])
      );
    end
  endgenerate

  // Checks
  a_brake_off_never: assert property (@(posedge core_clk) disable iff (rst)
    !brk_en |-> !brake_on) else $error("brake active with enable low");
  a_pin_polarity: assert property (@(posedge core_clk) disable iff (rst)
    brk_en && brk_pen && !brk_md && (brake_pin_s == brake_ctrl[BRK_POL_POS]) |-> brake_on)
    else $error("pin brake not applied");
  a_brake_level: assert property (@(posedge core_clk) disable iff (rst)
    brake_on |=> pwm_out == $past(brake_ctrl[3:0])) else $error("brake level wrong");
  a_soft_brake: assert property (@(posedge core_clk) disable iff (rst)
    brk_en && !brk_pen && !brk_md |-> brake_on) else $error("software brake missing");
  a_stop_brake: assert property (@(posedge core_clk) disable iff (rst)
    brk_en && !brk_pen && brk_md |-> brake_on == !run) else $error("stop brake wrong");
  a_pin_stops_run: assert property (@(posedge core_clk) disable iff (rst)
    pin_brake |=> !run && irq_status[IRQ_BRAKE_POS]) else $error("pin brake did not stop");
  a_mode_inert: assert property (@(posedge core_clk) disable iff (rst)
    brk_pen && brk_md |-> !brake_on) else $error("inert mode braked");
  a_count_wrap: assert property (@(posedge core_clk) disable iff (rst)
    run && !control_one[CTL_CLR_POS] && count >= period_act |=> count == 10'h000)
    else $error("counter did not wrap");
  a_count_step: assert property (@(posedge core_clk) disable iff (rst)
    run && !control_one[CTL_CLR_POS] && count < period_act |=> count == $past(count) + 10'h001)
    else $error("counter did not step");
  a_period_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_stb && addr == OFF_PERIOD_LOW |=> period_low == $past(wdata)) else $error("period write lost");
  a_duty_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_stb && addr == OFF_DUTY1_LOW |=> duty_low[1] == $past(wdata)) else $error("duty write lost");
  c_pin_brake: cover property (@(posedge core_clk) disable iff (rst) pin_brake);
  c_wrap: cover property (@(posedge core_clk) disable iff (rst) run && wrap);
  c_irq: cover property (@(posedge core_clk) disable iff (rst) irq);
  c_stop_brake: cover property (@(posedge core_clk) disable iff (rst) brk_md && !brk_pen && brake_on);
endmodule

// ---- testbench/pbu_brake_src.sv ----
// Purpose: Far-side model of the brake pin source feeding the generator
// Assumes: Pin driven push-pull, changes just after a rising edge
// Notes:   Idle level is the non-requesting level for the chosen polarity
`timescale 1ns/1ns
module pbu_brake_src (
  input  wire logic core_clk,
  input  wire logic req,
  input  wire logic active_high,
  output logic      brake_pin
);
  initial brake_pin = 1'b1;
  // Request level follows polarity, idle is its inverse
  always @(posedge core_clk) begin
    brake_pin <= req ? active_high : !active_high;
  end
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the PWM generator with brake
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Brake pin reaches outputs three cycles late, waits allow five
`timescale 1ns/1ns
module testbench;
  import pbu_pkg::*;
  logic       core_clk;
  logic       rst;
  logic       wr_stb;
  logic       rd_stb;
  logic       irq;
  logic       brk_req;
  logic       brk_high;
  logic       brake_pin;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [3:0] pwm_out;
  int         bad_count;
  int         num_checks;
  int         hi [4];
  int         exp_hi [4] = '{4, 0, 8, 2};

  pbu_top dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .brake_pin(brake_pin), .pwm_out(pwm_out), .irq(irq));
  pbu_brake_src load_side (.core_clk(core_clk), .req(brk_req), .active_high(brk_high),
    .brake_pin(brake_pin));

  always #10 core_clk = ~core_clk;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp,
                      input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d & mask, exp, what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Unbraked: channel 2 duty above period stays high, channel 1 duty 0 stays low
  task automatic chk_free(input string what);
    chk({6'h00, pwm_out[2:1]}, 8'h02, what);
  endtask

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    brk_req = 1'b0;
    brk_high = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rchk(OFF_PERIOD_LOW, 8'hFF, 8'hFF, "period low reset");
    rchk(OFF_HIGH_PERIOD, 8'hFF, 8'h03, "period high reset");
    rchk(OFF_DUTY0_LOW, 8'hFF, 8'h00, "duty0 low reset");
    rchk(OFF_BRAKE_CTRL, 8'hFF, 8'h00, "brake control reset");
    rchk(8'h00, 8'hFF, 8'h00, "unmapped read");
    wr(OFF_PERIOD_LOW, 8'h03);
    wr(OFF_HIGH_PERIOD, 8'h00);
    wr(OFF_DUTY0_LOW, 8'h02);
    wr(OFF_DUTY1_LOW, 8'h00);
    wr(OFF_DUTY2_LOW, 8'h04);
    wr(OFF_DUTY3_LOW, 8'h01);
    rchk(OFF_PERIOD_LOW, 8'hFF, 8'h03, "period low readback");
    rchk(OFF_DUTY0_LOW, 8'hFF, 8'h02, "duty0 low readback");
    rchk(OFF_DUTY1_LOW, 8'hFF, 8'h00, "duty1 low readback");
    $display("test registers done");
    // Period 3 gives four counts, two full periods sampled
    wr(OFF_CONTROL_ONE, 8'h80);
    wait_cyc(4);
    hi = '{default: 0};
    repeat (8) begin
      for (int i = 0; i < 4; i++) hi[i] += pwm_out[i];
      @(negedge core_clk);
    end
    for (int i = 0; i < 4; i++) chk(8'(hi[i]), 8'(exp_hi[i]), "high count per channel");
    $display("test pwm done");
    wr(OFF_BRAKE_CTRL, 8'h12);
    wait_cyc(3);
    chk({4'h0, pwm_out}, 8'h02, "software brake levels");
    wr(OFF_BRAKE_CTRL, 8'h02);
    wait_cyc(3);
    chk_free("brake disabled");
    wr(OFF_BRAKE_CTRL, 8'h92);
    wait_cyc(3);
    chk_free("stop mode while running");
    wr(OFF_CONTROL_ONE, 8'h00);
    wait_cyc(3);
    chk({4'h0, pwm_out}, 8'h02, "stop mode while stopped");
    wr(OFF_CONTROL_ONE, 8'h80);
    wait_cyc(3);
    chk_free("stop mode rerun");
    $display("test software brake done");
    wr(OFF_IRQ_ENABLE, 8'h01);
    wr(OFF_BRAKE_CTRL, 8'h32);
    wait_cyc(5);
    chk_free("pin idle high, polarity low");
    brk_req <= 1'b1;
    wait_cyc(5);
    chk({4'h0, pwm_out}, 8'h02, "pin brake levels");
    rchk(OFF_CONTROL_ONE, 8'h80, 8'h00, "run cleared by pin");
    rchk(OFF_IRQ_STATUS, 8'h01, 8'h01, "brake flag set");
    chk({7'h00, irq}, 8'h01, "irq raised");
    brk_req <= 1'b0;
    // Synchroniser must drain first, else a late pin set beats the clear
    wait_cyc(4);
    wr(OFF_IRQ_CLEAR, 8'h01);
    wait_cyc(2);
    rchk(OFF_IRQ_STATUS, 8'h01, 8'h00, "brake flag cleared");
    chk({7'h00, irq}, 8'h00, "irq dropped");
    // Swap polarity with brake disabled so the pin flip is no request
    wr(OFF_IRQ_ENABLE, 8'h00);
    wr(OFF_BRAKE_CTRL, 8'h62);
    brk_high <= 1'b1;
    wait_cyc(4);
    wr(OFF_BRAKE_CTRL, 8'h72);
    wr(OFF_CONTROL_ONE, 8'h80);
    wait_cyc(3);
    chk_free("pin idle low, polarity high");
    brk_req <= 1'b1;
    wait_cyc(5);
    chk({4'h0, pwm_out}, 8'h02, "pin high brake");
    rchk(OFF_IRQ_STATUS, 8'h01, 8'h01, "flag set while masked");
    chk({7'h00, irq}, 8'h00, "irq masked");
    brk_req <= 1'b0;
    wait_cyc(4);
    wr(OFF_IRQ_CLEAR, 8'h01);
    $display("test pin brake done");
    // Polarity high so the raised pin is a real request that mode three ignores
    wr(OFF_BRAKE_CTRL, 8'hF2);
    wr(OFF_CONTROL_ONE, 8'h80);
    brk_req <= 1'b1;
    wait_cyc(5);
    chk_free("pin ignored in mode three");
    rchk(OFF_CONTROL_ONE, 8'h80, 8'h80, "run kept");
    rchk(OFF_IRQ_STATUS, 8'h01, 8'h00, "no flag");
    $display("test no action mode done");
    wr(OFF_BRAKE_CTRL, 8'h00);
    brk_req <= 1'b0;
    wr(OFF_CONTROL_ONE, 8'h90);
    rchk(OFF_CONTROL_ONE, 8'h10, 8'h00, "counter clear self-clears");
    rchk(OFF_IRQ_STATUS, 8'h02, 8'h02, "wrap flag set");
    wr(OFF_CONTROL_ONE, 8'h09);
    wait_cyc(3);
    chk({4'h0, pwm_out}, 8'h09, "stopped outputs follow invert");
    $display("test control bits done");
    test_done();
  end
endmodule
